// file: hw/ledc_pkg.sv
package ledc_pkg;
  localparam int CHANNELS = 8;
  localparam logic [6:0] DEV_ADDR = 7'h1B;
  localparam logic [2:0] CTL_APPLY = 3'h0;
  localparam logic [2:0] CTL_STAGE = 3'h1;
  localparam logic [2:0] CTL_WR_APPLY = 3'h2;
  localparam logic [2:0] CTL_ALL_CUR = 3'h3;
  localparam logic [2:0] CTL_ALL_PWM = 3'h4;
  localparam logic [4:0] REG_CUR_BASE = 5'h00;
  localparam logic [4:0] REG_CH8_CUR = 5'h07;
  localparam logic [4:0] REG_PWM_BASE = 5'h08;
  localparam logic [4:0] REG_CH1_PWM = 5'h08;
  localparam logic [4:0] REG_OUT_EN = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h11;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LOWPWR_MASK = 8'h04;
  localparam int SYS_CLK_KHZ = 10000;
  localparam int IDLE_TIME_US = 5000;
  localparam int IDLE_CYCLES = (IDLE_TIME_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int WAKE_TIME_US = 1000;
  localparam int WAKE_CYCLES = (WAKE_TIME_US * SYS_CLK_KHZ) / 1000 - 1;
  localparam int SCL_QTR_CYCLES = 5;
  localparam logic [3:0] WB_CMD = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_CTL_LSB = 13;
  localparam int CMD_OP_LSB = 16;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_APPLY = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RX = 3'b001, ST_ACK = 3'b011, ST_TX = 3'b010, ST_TACK = 3'b110
  } ledc_dev_state_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_START = 2'b01, H_BYTE = 2'b11, H_STOP = 2'b10
  } ledc_host_state_e;
endpackage

// file: hw/ledc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ledc_if;
  logic scl;
  logic sda;
  logic hSclOut;
  logic hSclOe;
  logic hSdaOut;
  logic hSdaOe;
  logic dSdaOut;
  logic dSdaOe;
  // open drain: a driver can only pull low, the pull-up wins otherwise
  assign scl = ~(hSclOe & ~hSclOut);
  assign sda = ~((hSdaOe & ~hSdaOut) | (dSdaOe & ~dSdaOut));
  modport host(input scl, input sda, output hSclOut, output hSclOe, output hSdaOut,
    output hSdaOe);
  modport dev(input scl, input sda, output dSdaOut, output dSdaOe);
endinterface
`default_nettype wire

// file: hw/ledc_device.sv
`timescale 1ns/1ps
`default_nettype none
module ledc_device import ledc_pkg::*; #(
  parameter int IDLE_CYC = IDLE_CYCLES,
  parameter int WAKE_CYC = WAKE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  ledc_if.dev bus,
  output logic [7:0] chanEnable,
  output logic [63:0] chanCurrent,
  output logic [63:0] chanPwm,
  output logic lowPower,
  output logic pumpEnable
);
  logic sclS1_r;
  logic sclS2_r;
  logic sclD_r;
  logic sdaS1_r;
  logic sdaS2_r;
  logic sdaD_r;
  ledc_dev_state_e state_r;
  logic [3:0] bitCnt_r;
  logic [1:0] byteIdx_r;
  logic [7:0] shReg_r;
  logic [7:0] txReg_r;
  logic rw_r;
  logic [2:0] ctl_r;
  logic [4:0] regAddr_r;
  logic sdaLow_r;
  logic applyPend_r;
  logic [7:0] stgCur_r [CHANNELS];
  logic [7:0] stgPwm_r [CHANNELS];
  logic [7:0] actCur_r [CHANNELS];
  logic [7:0] actPwm_r [CHANNELS];
  logic [7:0] stgEn_r;
  logic [7:0] actEn_r;
  logic [16:0] lpTimer_r;
  logic [13:0] wakeCnt_r;
  logic lowPower_r;
  logic waking_r;
  logic pumpEnable_r;

  // the third stage compares against the synchronised level only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclS1_r <= 1'b1;
      sclS2_r <= 1'b1;
      sclD_r <= 1'b1;
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclS1_r <= bus.scl;
      sclS2_r <= sclS1_r;
      sclD_r <= sclS2_r;
      sdaS1_r <= bus.sda;
      sdaS2_r <= sdaS1_r;
      sdaD_r <= sdaS2_r;
    end
  end

  wire sclRise = sclS2_r & ~sclD_r;
  wire sclFall = ~sclS2_r & sclD_r;
  wire startDet = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
  wire stopDet = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
  wire byteDone = (state_r == ST_RX) && sclFall && (bitCnt_r == 4'd8);
  wire addrMatch = (shReg_r[7:1] == DEV_ADDR);
  wire addrHit = byteDone && (byteIdx_r == 2'd0) && addrMatch;
  wire ctlDone = byteDone && (byteIdx_r == 2'd1);
  wire dataDone = byteDone && (byteIdx_r == 2'd2) && !rw_r;
  // only address, control and one data byte are acknowledged
  wire ackThis = (byteIdx_r == 2'd0) ? addrMatch : (byteIdx_r != 2'd3);
  wire isSingle = (ctl_r == CTL_STAGE) || (ctl_r == CTL_WR_APPLY);
  wire applyNow = (ctlDone && (shReg_r[7:5] == CTL_APPLY))
    || (dataDone && (ctl_r == CTL_WR_APPLY));
  wire [7:0] statusByte = lowPower_r ? LOWPWR_MASK : 8'h00;
  // channel and enable reads see staged values, which is what the last write left; status reads the live flag
  wire [7:0] readData = (regAddr_r < REG_PWM_BASE) ? stgCur_r[regAddr_r[2:0]] :
    (regAddr_r < REG_OUT_EN) ? stgPwm_r[regAddr_r[2:0]] :
    (regAddr_r == REG_OUT_EN) ? stgEn_r :
    (regAddr_r == REG_STATUS) ? statusByte : 8'h00;
  wire activity = addrHit || (|actEn_r);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      byteIdx_r <= 2'h0;
      shReg_r <= 8'h00;
      txReg_r <= 8'h00;
      rw_r <= 1'b0;
      ctl_r <= 3'h0;
      regAddr_r <= 5'h00;
      sdaLow_r <= 1'b0;
    end else if (startDet) begin
      state_r <= ST_RX;
      bitCnt_r <= 4'h0;
      byteIdx_r <= 2'h0;
      sdaLow_r <= 1'b0;
    end else if (stopDet) begin
      state_r <= ST_IDLE;
      sdaLow_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (sclRise && (bitCnt_r < 4'd8)) begin
            shReg_r <= {shReg_r[6:0], sdaS2_r};
            bitCnt_r <= bitCnt_r + 4'd1;
          end else if (byteDone) begin
            if (byteIdx_r == 2'd0) begin
              rw_r <= shReg_r[0];
            end
            if (byteIdx_r == 2'd1) begin
              ctl_r <= shReg_r[7:5];
              regAddr_r <= shReg_r[4:0];
            end
            if (byteIdx_r != 2'd3) begin
              byteIdx_r <= byteIdx_r + 2'd1;
            end
            state_r <= ackThis ? ST_ACK : ST_IDLE;
            sdaLow_r <= ackThis;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (rw_r) begin
              state_r <= ST_TX;
              txReg_r <= readData;
              sdaLow_r <= ~readData[7];
              bitCnt_r <= 4'd1;
            end else begin
              state_r <= ST_RX;
              sdaLow_r <= 1'b0;
              bitCnt_r <= 4'd0;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_r == 4'd8) begin
              state_r <= ST_TACK;
              sdaLow_r <= 1'b0;
            end else begin
              sdaLow_r <= ~txReg_r[6];
              txReg_r <= {txReg_r[6:0], 1'b0};
              bitCnt_r <= bitCnt_r + 4'd1;
            end
          end
        end
        ST_TACK: begin
          // a master ack asks for the same register again
          if (sclRise) begin
            state_r <= sdaS2_r ? ST_IDLE : ST_ACK;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      applyPend_r <= 1'b0;
      stgEn_r <= REG_RESET;
      actEn_r <= REG_RESET;
    end else begin
      // apply one cycle late so a 010 write lands before the copy
      applyPend_r <= applyNow;
      if (dataDone && isSingle && (regAddr_r == REG_OUT_EN)) begin
        stgEn_r <= shReg_r;
      end
      if (applyPend_r) begin
        actEn_r <= stgEn_r;
      end
    end
  end

  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : gCh
      wire [4:0] curAddr = REG_CUR_BASE + 5'(i);
      wire [4:0] pwmAddr = REG_PWM_BASE + 5'(i);
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          stgCur_r[i] <= REG_RESET;
          stgPwm_r[i] <= REG_RESET;
          actCur_r[i] <= REG_RESET;
          actPwm_r[i] <= REG_RESET;
        end else begin
          if (dataDone && ((ctl_r == CTL_ALL_CUR) || (isSingle && regAddr_r == curAddr))) begin
            stgCur_r[i] <= shReg_r;
          end
          if (dataDone && ((ctl_r == CTL_ALL_PWM) || (isSingle && regAddr_r == pwmAddr))) begin
            stgPwm_r[i] <= shReg_r;
          end
          if (applyPend_r) begin
            actCur_r[i] <= stgCur_r[i];
            actPwm_r[i] <= stgPwm_r[i];
          end
        end
      end
      assign chanCurrent[8*i +: 8] = actCur_r[i];
      assign chanPwm[8*i +: 8] = actPwm_r[i];
    end
  endgenerate

  // registers are never touched here: low power only gates the pump
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lpTimer_r <= 17'h00000;
      lowPower_r <= 1'b0;
      waking_r <= 1'b0;
      wakeCnt_r <= 14'h0000;
      pumpEnable_r <= 1'b1;
    end else begin
      if (activity || lowPower_r) begin
        lpTimer_r <= 17'h00000;
      end else if (lpTimer_r == 17'(IDLE_CYC - 1)) begin
        lowPower_r <= 1'b1;
        lpTimer_r <= 17'h00000;
      end else begin
        lpTimer_r <= lpTimer_r + 17'h00001;
      end
      if (lowPower_r && addrHit && !waking_r) begin
        waking_r <= 1'b1;
        wakeCnt_r <= 14'h0000;
      end else if (waking_r) begin
        if (wakeCnt_r == 14'(WAKE_CYC - 1)) begin
          waking_r <= 1'b0;
          lowPower_r <= 1'b0;
        end else begin
          wakeCnt_r <= wakeCnt_r + 14'h0001;
        end
      end
      pumpEnable_r <= !lowPower_r || waking_r;
    end
  end

  assign chanEnable = actEn_r;
  assign lowPower = lowPower_r;
  assign pumpEnable = pumpEnable_r;
  assign bus.dSdaOut = 1'b0;
  assign bus.dSdaOe = sdaLow_r;
endmodule
`default_nettype wire

// file: hw/ledc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ledc_host import ledc_pkg::*; #(
  parameter int QTR = SCL_QTR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  ledc_if.host bus,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  ledc_host_state_e state_r;
  logic [2:0] step_r;
  logic [1:0] ph_r;
  logic [3:0] bitCnt_r;
  logic [7:0] tickCnt_r;
  logic sclLow_r;
  logic sdaLow_r;
  logic sdaS1_r;
  logic sdaS2_r;
  logic busy_r;
  logic nack_r;
  logic [7:0] rxSh_r;
  logic [7:0] rdata_r;
  logic [1:0] op_r;
  logic [2:0] ctl_r;
  logic [4:0] addr_r;
  logic [7:0] data_r;

  // element sequence: start, addr, control, then data / stop / repeated start
  function automatic ledc_host_state_e elemOf(input logic [2:0] s, input logic [1:0] op);
    case (s)
      3'd0: elemOf = H_START;
      3'd1, 3'd2: elemOf = H_BYTE;
      3'd3: elemOf = (op == OP_WRITE) ? H_BYTE : (op == OP_READ) ? H_START : H_STOP;
      3'd4: elemOf = (op == OP_READ) ? H_BYTE : H_STOP;
      3'd5: elemOf = H_BYTE;
      default: elemOf = H_STOP;
    endcase
  endfunction

  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a command lands at the edge that shows ack, the same edge at which the master sees it
  wire cmdLoad = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (wb_adr_i == WB_CMD) &
    (&wb_sel_i[2:0]) & ~busy_r;
  wire tick = (state_r != H_IDLE) && (tickCnt_r == 8'(QTR - 1));
  wire rxMode = (step_r == 3'd5);
  wire [7:0] txByte = (step_r == 3'd1) ? {DEV_ADDR, 1'b0} :
    (step_r == 3'd2) ? {ctl_r, addr_r} :
    (step_r == 3'd3) ? data_r : {DEV_ADDR, 1'b1};
  wire txBit0 = (bitCnt_r < 4'd8) && !rxMode && !txByte[3'(4'd7 - bitCnt_r)];
  wire [2:0] stepNext = step_r + 3'd1;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
    end else begin
      sdaS1_r <= bus.sda;
      sdaS2_r <= sdaS1_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= H_IDLE;
      step_r <= 3'd0;
      ph_r <= 2'd0;
      bitCnt_r <= 4'd0;
      tickCnt_r <= 8'h00;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      rxSh_r <= 8'h00;
      rdata_r <= 8'h00;
      op_r <= OP_WRITE;
      ctl_r <= 3'h0;
      addr_r <= 5'h00;
      data_r <= 8'h00;
    end else if (cmdLoad) begin
      op_r <= wb_dat_i[CMD_OP_LSB +: 2];
      // reads always carry the staging code; apply-only always carries 000
      ctl_r <= (wb_dat_i[CMD_OP_LSB +: 2] == OP_READ) ? CTL_STAGE :
        (wb_dat_i[CMD_OP_LSB +: 2] == OP_APPLY) ? CTL_APPLY : wb_dat_i[CMD_CTL_LSB +: 3];
      addr_r <= wb_dat_i[CMD_ADDR_LSB +: 5];
      data_r <= wb_dat_i[CMD_DATA_LSB +: 8];
      busy_r <= 1'b1;
      nack_r <= 1'b0;
      state_r <= H_START;
      step_r <= 3'd0;
      ph_r <= 2'd0;
      tickCnt_r <= 8'h00;
    end else if (state_r != H_IDLE) begin
      tickCnt_r <= tick ? 8'h00 : tickCnt_r + 8'h01;
      if (tick) begin
        ph_r <= ph_r + 2'd1;
        case (state_r)
          H_START: begin
            case (ph_r)
              2'd0: begin
                sclLow_r <= 1'b1;
                sdaLow_r <= 1'b0;
              end
              2'd1: sclLow_r <= 1'b0;
              2'd2: sdaLow_r <= 1'b1;
              default: begin
                sclLow_r <= 1'b1;
                bitCnt_r <= 4'd0;
                step_r <= stepNext;
                state_r <= elemOf(stepNext, op_r);
              end
            endcase
          end
          H_BYTE: begin
            case (ph_r)
              2'd0: sdaLow_r <= txBit0;
              2'd1: sclLow_r <= 1'b0;
              2'd2: begin
                if (bitCnt_r < 4'd8) begin
                  rxSh_r <= {rxSh_r[6:0], sdaS2_r};
                end else if (!rxMode && sdaS2_r) begin
                  nack_r <= 1'b1;
                end
              end
              default: begin
                sclLow_r <= 1'b1;
                bitCnt_r <= bitCnt_r + 4'd1;
                if (bitCnt_r == 4'd8) begin
                  bitCnt_r <= 4'd0;
                  if (rxMode) begin
                    rdata_r <= rxSh_r;
                  end
                  step_r <= nack_r ? 3'd7 : stepNext;
                  state_r <= nack_r ? H_STOP : elemOf(stepNext, op_r);
                end
              end
            endcase
          end
          H_STOP: begin
            case (ph_r)
              2'd0: begin
                sclLow_r <= 1'b1;
                sdaLow_r <= 1'b1;
              end
              2'd1: sclLow_r <= 1'b0;
              2'd2: sdaLow_r <= 1'b0;
              default: begin
                state_r <= H_IDLE;
                busy_r <= 1'b0;
              end
            endcase
          end
          default: state_r <= H_IDLE;
        endcase
      end
    end
  end

  wire [31:0] cmdWord = {14'h0000, op_r, ctl_r, addr_r, data_r};
  wire [31:0] statWord = {16'h0000, rdata_r, 6'h00, nack_r, busy_r};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= (wb_adr_i == WB_CMD) ? cmdWord :
        (wb_adr_i == WB_STATUS) ? statWord : 32'h00000000;
    end
  end

  assign bus.hSclOut = 1'b0;
  assign bus.hSclOe = sclLow_r;
  assign bus.hSdaOut = 1'b0;
  assign bus.hSdaOe = sdaLow_r;
endmodule
`default_nettype wire

// file: verif/ledc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ledc_asserts #(
  parameter int WAKE_CYC = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dSdaOe,
  input wire logic [7:0] chanEnable,
  input wire logic [63:0] chanCurrent,
  input wire logic lowPower,
  input wire logic pumpEnable
);
  // two cycles of slack over WAKE_CYC in the window from the pump turning on to the flag clearing
  localparam int WAKE_MAX = WAKE_CYC + 2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_entry_idle;
    $rose(lowPower) |-> chanEnable == 8'h00 && scl && sda;
  endproperty
  a_entry_idle: assert property (p_entry_idle) else $error("sleep entered while busy");
  property p_pump_off;
    $rose(lowPower) |=> !pumpEnable;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump still on in sleep");
  property p_keep_out;
    !pumpEnable && !$past(pumpEnable) |-> $stable(chanCurrent) && $stable(chanEnable);
  endproperty
  a_keep_out: assert property (p_keep_out) else $error("outputs changed in sleep");
  property p_flag_held;
    !pumpEnable |-> lowPower;
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag low while pump off");
  property p_wake_hold;
    $rose(pumpEnable) |-> lowPower [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("flag cleared before settled");
  property p_wake_pump;
    $fell(lowPower) |-> pumpEnable;
  endproperty
  a_wake_pump: assert property (p_wake_pump) else $error("flag cleared with pump off");
  property p_wake_time;
    $rose(pumpEnable) |-> ##[1:WAKE_MAX] !lowPower;
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("wake took too long");
  property p_sda_change;
    $changed(dSdaOe) |-> !scl;
  endproperty
  a_sda_change: assert property (p_sda_change) else $error("device moved sda with scl high");
  property p_enabled_awake;
    chanEnable != 8'h00 && !lowPower |=> !lowPower;
  endproperty
  a_enabled_awake: assert property (p_enabled_awake) else $error("slept with channel on");
  c_sleep: cover property ($rose(lowPower));
  c_wake: cover property ($fell(lowPower));
  c_ack: cover property ($rose(dSdaOe));
  c_lit: cover property (chanEnable == 8'h8F);
endmodule
`default_nettype wire

// file: verif/ledc_test.sv
`timescale 1ns/1ps
`default_nettype none
module ledc_test import ledc_pkg::*;;
  // short counts keep the run small; wake stays long enough to read the flag set
  localparam int IDLE = 1000;
  localparam int WAKE = 900;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] wbAdr = 4'h0;
  logic [31:0] wbDat = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic wbWe = 1'h0;
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [7:0] chanEnable;
  logic [63:0] chanCurrent;
  logic [63:0] chanPwm;
  logic lowPower;
  logic pumpEnable;
  int fails = 0;
  int check_count = 0;
  logic [31:0] st;
  logic [7:0] d1;
  logic [7:0] d2;
  logic [7:0] rd;
  logic [4:0] ra;
  int n;
  always #50 sys_clk = ~sys_clk;
  ledc_if bus_if();
  ledc_host #(.QTR(5)) ledc_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
  ledc_device #(.IDLE_CYC(IDLE), .WAKE_CYC(WAKE)) ledc_device_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .bus(bus_if), .chanEnable(chanEnable), .chanCurrent(chanCurrent),
    .chanPwm(chanPwm), .lowPower(lowPower), .pumpEnable(pumpEnable));
  ledc_asserts #(.WAKE_CYC(WAKE)) ledc_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl(bus_if.scl), .sda(bus_if.sda), .dSdaOe(bus_if.dSdaOe), .chanEnable(chanEnable),
    .chanCurrent(chanCurrent), .lowPower(lowPower), .pumpEnable(pumpEnable));
  function automatic logic [63:0] cur_exp(input logic [7:0] all, input logic [7:0] c8);
    return {c8, {7{all}}};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= 4'hF;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wbAck !== 1'h1 && k < 50);
    if (k >= 50) begin
      fails++;
      finish_test();
    end
    q = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
  endtask
  // every command runs to the end of its stop before the next one starts
  task automatic cmd(input logic [1:0] op, input logic [2:0] ctl, input logic [4:0] a,
      input logic [7:0] d);
    int k;
    wb(1'h1, WB_CMD, {14'h0, op, ctl, a, d}, st);
    k = 0;
    do begin
      wb(1'h0, WB_STATUS, 32'h0, st);
      k++;
    end while (st[0] !== 1'h0 && k < 2000);
    if (k >= 2000) begin
      fails++;
      finish_test();
    end
    chk("nack", st[1], 1'h0);
  endtask
  task automatic rdreg(input logic [4:0] a, input logic [7:0] exp, input string what);
    cmd(OP_READ, CTL_STAGE, a, 8'h00);
    chk(what, st[15:8], exp);
  endtask
  initial begin
    void'($urandom(32'hD254));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    d1 = 8'($urandom());
    d2 = 8'($urandom());
    rdreg(REG_CH8_CUR, 8'h00, "reset level");
    wb(1'h0, 4'h8, 32'h0, st);
    chk("unmapped", st, 32'h0);
    cmd(OP_WRITE, CTL_ALL_CUR, 5'h1F, d1);
    chk("staged current", chanCurrent, 64'h0);
    rdreg(5'h03, d1, "bcast cur");
    cmd(OP_WRITE, CTL_STAGE, REG_CH8_CUR, 8'h0B);
    rdreg(REG_CH8_CUR, 8'h0B, "ch8 cur");
    cmd(OP_WRITE, CTL_ALL_PWM, 5'h00, d2);
    rdreg(REG_CH1_PWM, d2, "ch1 pwm");
    rdreg(5'h0F, d2, "ch8 pwm");
    cmd(OP_WRITE, CTL_STAGE, REG_OUT_EN, 8'h8F);
    chk("staged enable", chanEnable, 8'h00);
    rdreg(REG_OUT_EN, 8'h8F, "enable reg");
    cmd(OP_APPLY, CTL_APPLY, 5'h00, 8'h00);
    chk("applied enable", chanEnable, 8'h8F);
    chk("applied current", chanCurrent, cur_exp(d1, 8'h0B));
    chk("applied pwm", chanPwm, {8{d2}});
    for (int i = 0; i < 4; i++) begin
      ra = 5'(8 + $urandom_range(7));
      rd = 8'($urandom());
      cmd(OP_WRITE, CTL_STAGE, ra, rd);
      rdreg(ra, rd, "random pwm");
    end
    chk("pwm held", chanPwm, {8{d2}});
    cmd(OP_WRITE, CTL_WR_APPLY, REG_OUT_EN, 8'h0F);
    chk("wr apply", chanEnable, 8'h0F);
    cmd(OP_WRITE, CTL_STAGE, REG_STATUS, 8'hFF);
    rdreg(REG_STATUS, 8'h00, "status ro");
    repeat (IDLE + 50) @(posedge sys_clk);
    chk("awake while on", lowPower, 1'h0);
    cmd(OP_WRITE, CTL_WR_APPLY, REG_OUT_EN, 8'h00);
    n = 0;
    while (lowPower !== 1'h1 && n < IDLE + 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= IDLE + 50) begin
      fails++;
      finish_test();
    end
    chk("idle entry", n > IDLE - 80 && n <= IDLE, 1'h1);
    @(posedge sys_clk);
    chk("pump off", pumpEnable, 1'h0);
    rdreg(REG_STATUS, LOWPWR_MASK, "flag set");
    n = 0;
    do begin
      cmd(OP_READ, CTL_STAGE, REG_STATUS, 8'h00);
      n++;
    end while (st[15:8] !== 8'h00 && n < 10);
    if (st[15:8] !== 8'h00) begin
      fails++;
      finish_test();
    end
    chk("flag cleared", st[15:8], 8'h00);
    chk("wake time", n <= 3, 1'h1);
    rdreg(REG_CH8_CUR, 8'h0B, "kept level");
    finish_test();
  end
endmodule
`default_nettype wire
